// ### sps_sample_pipeline.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Each input is a 12-bit converter code spanning 4095 steps.
// - The run output is lit until 100 ms pass with no coupler exchange.
// - By default the process word is a two's complement integer.
// - The feature register selects sign-magnitude or an alternate format.
// - Default scaling maps 0 V, 5 V, 10 V to 0x0000, 0x3FFF, 0x7FFF.
// - Sampling runs continuously and each code lands in the raw register.
// - Calibrated value is raw plus vendor offset, times vendor gain.
// - With both scalings off the calibrated value is output as is.
// - Manufacturer scaling alone outputs its offset plus gain times value.
// - User scaling alone outputs user offset plus user gain times value.
// - With both on, user scaling is applied to the manufacturer result.
// - Feature register bits switch the two scaling stages on and off.
// - One 16-bit data word and one 8-bit status byte go to the coupler.
module sps_sample_pipeline
  import sps_pkg::*;
#(
  parameter int WDOG_CYCLES = WDOG_CYCLES_DEF
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             convStart,
  input  wire logic [11:0] adcCode,
  input  wire logic        adcDone,
  input  wire logic        pdExchange,
  output sps_pdata_t       pdOut,
  output logic             pdValid,
  output logic             runLed,
  output logic             irq
);

  localparam int WDW = $clog2(WDOG_CYCLES + 1);

  // Bus slave: address phase capture
  wire logic       addrPhase = hsel & htrans[1] & hready & ce;
  wire logic [5:0] aIdx      = haddr[7:2];
  wire logic       inMap     = haddr[31:8] == 24'h00_0000;
  wire logic       hsizeWord = hsize == 3'h2;

  logic             wrPend_q;
  logic [5:0]       wrIdx_q;
  logic [31:0]      hrdata_q;

  logic [11:0]      raw_q;
  sps_line_t        vend_q;
  sps_line_t        maker_q;
  sps_line_t        user_q;
  logic [15:0]      feat_q;
  logic [IRQ_BITS-1:0] irqStat_q;
  logic [IRQ_BITS-1:0] irqMask_q;

  sps_seq_t         seq_q;
  sps_seq_t         seq_d;
  logic [15:0]      cal_q;
  logic             calHi_q;
  logic             calLo_q;
  sps_pdata_t       pd_q;
  logic             pdValid_q;

  logic [2:0]       pdSync_q;
  logic             pdLvl_q;
  logic [WDW-1:0]   wdCnt_q;
  logic             wdExp_q;

  // Write data phase
  wire logic wrNow = wrPend_q & ce;
  wire logic wrVendOfs   = wrNow & (wrIdx_q == IDX_VEND_OFS);
  wire logic wrVendGain  = wrNow & (wrIdx_q == IDX_VEND_GAIN);
  wire logic wrMakerOfs  = wrNow & (wrIdx_q == IDX_MAKER_OFS);
  wire logic wrMakerGain = wrNow & (wrIdx_q == IDX_MAKER_GAIN);
  wire logic wrFeature   = wrNow & (wrIdx_q == IDX_FEATURE);
  wire logic wrUserOfs   = wrNow & (wrIdx_q == IDX_USER_OFS);
  wire logic wrUserGain  = wrNow & (wrIdx_q == IDX_USER_GAIN);
  wire logic wrIrqMask   = wrNow & (wrIdx_q == IDX_IRQ_MASK);
  wire logic [15:0] wData = hwdata[15:0];

  // Read selection, unmapped reads give zero
  wire logic [31:0] rdWord =
    !inMap                      ? 32'h0000_0000 :
    (aIdx == IDX_RAW_SAMPLE)    ? {20'h0_0000, raw_q} :
    (aIdx == IDX_VEND_OFS)      ? {16'h0000, vend_q.offset} :
    (aIdx == IDX_VEND_GAIN)     ? {16'h0000, vend_q.gain} :
    (aIdx == IDX_MAKER_OFS)     ? {16'h0000, maker_q.offset} :
    (aIdx == IDX_MAKER_GAIN)    ? {16'h0000, maker_q.gain} :
    (aIdx == IDX_FEATURE)       ? {16'h0000, feat_q} :
    (aIdx == IDX_USER_OFS)      ? {16'h0000, user_q.offset} :
    (aIdx == IDX_USER_GAIN)     ? {16'h0000, user_q.gain} :
    (aIdx == IDX_IRQ_STAT)      ? {29'h0000_0000, irqStat_q} :
    (aIdx == IDX_IRQ_MASK)      ? {29'h0000_0000, irqMask_q} :
    (aIdx == IDX_PD_WORD)       ? {8'h00, pd_q} :
    32'h0000_0000;

  wire logic rdStat = addrPhase & ~hwrite & inMap & (aIdx == IDX_IRQ_STAT);

  assign hrdata    = hrdata_q;
  assign hreadyout = ce;
  assign hresp     = 1'b0;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wrPend_q <= 1'b0;
      wrIdx_q  <= 6'h00;
      hrdata_q <= 32'h0000_0000;
    end else if (ce) begin
      wrPend_q <= addrPhase & hwrite & inMap & hsizeWord;
      if (addrPhase) begin
        wrIdx_q <= aIdx;
      end
      if (addrPhase & ~hwrite) begin
        hrdata_q <= rdWord;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      vend_q  <= '{offset: RST_VEND_OFS,  gain: RST_VEND_GAIN};
      maker_q <= '{offset: RST_MAKER_OFS, gain: RST_MAKER_GAIN};
      user_q  <= '{offset: RST_USER_OFS,  gain: RST_USER_GAIN};
    end else begin
      if (wrVendOfs) vend_q.offset <= wData;
      if (wrVendGain) vend_q.gain <= wData;
      if (wrMakerOfs) maker_q.offset <= wData;
      if (wrMakerGain) maker_q.gain <= wData;
      if (wrUserOfs) user_q.offset <= wData;
      if (wrUserGain) user_q.gain <= wData;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      feat_q    <= RST_FEATURE;
      irqMask_q <= RST_IRQ_MASK;
    end else begin
      if (wrFeature) feat_q <= wData;
      if (wrIrqMask) irqMask_q <= wData[IRQ_BITS-1:0];
    end
  end

  // Sample sequencer: start, wait, calibrate, scale
  always_comb begin
    unique case (seq_q)
      SEQ_START: seq_d = SEQ_WAIT;
      SEQ_WAIT:  seq_d = adcDone ? SEQ_CAL : SEQ_WAIT;
      SEQ_CAL:   seq_d = SEQ_OUT;
      SEQ_OUT:   seq_d = SEQ_START;
    endcase
  end

  assign convStart = ce & (seq_q == SEQ_START);

  wire logic adcTake = ce & (seq_q == SEQ_WAIT) & adcDone;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      seq_q <= SEQ_START;
      raw_q <= 12'h000;
    end else if (ce) begin
      seq_q <= seq_d;
      if (adcTake) raw_q <= adcCode;
    end
  end

  // Calibration and scaling chain
  wire logic [15:0] vendOut;
  wire logic        vendHi;
  wire logic        vendLo;
  wire logic [15:0] makerOut;
  wire logic        makerHi;
  wire logic        makerLo;
  wire logic [15:0] userOut;
  wire logic        userHi;
  wire logic        userLo;

  sps_scale_stage #(.OFFSET_FIRST(1'b1)) uVend (
    .xIn    ({4'h0, raw_q}),
    .line   (vend_q),
    .yOut   (vendOut),
    .clipHi (vendHi),
    .clipLo (vendLo)
  );

  sps_scale_stage #(.OFFSET_FIRST(1'b0)) uMaker (
    .xIn    (cal_q),
    .line   (maker_q),
    .yOut   (makerOut),
    .clipHi (makerHi),
    .clipLo (makerLo)
  );

  wire logic userEn  = feat_q[FEAT_USER_EN];
  wire logic makerEn = feat_q[FEAT_MAKER_EN];
  wire logic [15:0] userIn = makerEn ? makerOut : cal_q;

  sps_scale_stage #(.OFFSET_FIRST(1'b0)) uUser (
    .xIn    (userIn),
    .line   (user_q),
    .yOut   (userOut),
    .clipHi (userHi),
    .clipLo (userLo)
  );

  wire logic [15:0] scaled =
    userEn  ? userOut :
    makerEn ? makerOut :
    cal_q;

  wire logic over  = calHi_q | (makerEn & makerHi) | (userEn & userHi);
  wire logic under = calLo_q | (makerEn & makerLo) | (userEn & userLo);

  // Output number formats
  wire sps_fmt_t fmt = sps_fmt_t'(feat_q[FEAT_FMT_LSB +: 2]);
  wire logic [15:0] negVal = 16'(~scaled + 16'h0001);
  wire logic [14:0] magVal =
    (scaled == PD_MIN) ? PD_MAX[14:0] : negVal[14:0];
  wire logic [15:0] signMag =
    scaled[15] ? {1'b1, magVal} : scaled;
  wire logic [15:0] altWord = {scaled[15:3], 1'b0, under, over};
  wire logic [15:0] fmtWord =
    (fmt == FMT_SIGNMAG) ? signMag :
    (fmt == FMT_ALT)     ? altWord :
    scaled;

  wire logic [7:0] statusByte =
    8'({wdExp_q, under, over} << STB_OVER);

  wire logic outNow = ce & (seq_q == SEQ_OUT);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cal_q   <= 16'h0000;
      calHi_q <= 1'b0;
      calLo_q <= 1'b0;
    end else if (ce && seq_q == SEQ_CAL) begin
      cal_q   <= vendOut;
      calHi_q <= vendHi;
      calLo_q <= vendLo;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pd_q      <= '{data: 16'h0000, status: 8'h00};
      pdValid_q <= 1'b0;
    end else if (ce) begin
      pdValid_q <= outNow;
      if (outNow) pd_q <= '{data: fmtWord, status: statusByte};
    end
  end

  assign pdOut   = pd_q;
  assign pdValid = pdValid_q;

  // Coupler exchange strobe: three stage synchroniser
  wire logic pdAgree = pdSync_q[1] == pdSync_q[2];
  wire logic exchEvt = pdAgree & pdSync_q[2] & ~pdLvl_q;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pdSync_q <= 3'h0;
      pdLvl_q  <= 1'b0;
    end else if (ce) begin
      pdSync_q <= {pdSync_q[1:0], pdExchange};
      if (pdAgree) pdLvl_q <= pdSync_q[2];
    end
  end

  // Watchdog on coupler process data exchange
  wire logic wdHit = wdCnt_q == WDW'(WDOG_CYCLES - 1);
  wire logic wdogEvt = ce & wdHit & ~wdExp_q & ~exchEvt;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wdCnt_q <= '0;
      wdExp_q <= 1'b0;
    end else if (ce) begin
      if (exchEvt) begin
        wdCnt_q <= '0;
        wdExp_q <= 1'b0;
      end else if (wdHit) begin
        wdExp_q <= 1'b1;
      end else begin
        wdCnt_q <= wdCnt_q + WDW'(1);
      end
    end
  end

  assign runLed = ~wdExp_q;

  // Sticky interrupt status, set wins over clear on read
  wire logic [IRQ_BITS-1:0] irqEvt =
    IRQ_BITS'({wdogEvt, outNow & (over | under), outNow});
  wire logic [IRQ_BITS-1:0] irqClr = {IRQ_BITS{rdStat}};

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irqStat_q <= '0;
    end else if (ce) begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

endmodule
`default_nettype wire

// ### sps_pkg.sv
`default_nettype none
package sps_pkg;

  // Converter and process data widths
  localparam int ADC_BITS = 12;
  localparam logic [11:0] ADC_FULL_SCALE = 12'hFFF;
  localparam int PD_BITS = 16;
  localparam int ST_BITS = 8;

  // Gains are signed fixed point with this many fraction bits
  localparam int GAIN_FRAC = 10;

  // Output limits
  localparam logic [15:0] PD_MAX = 16'h7FFF;
  localparam logic [15:0] PD_MIN = 16'h8000;

  // Watchdog time and clock rate
  localparam int CLK_KHZ = 25_000;
  localparam int WDOG_TIME_MS = 100;
  localparam int WDOG_CYCLES_DEF = WDOG_TIME_MS * CLK_KHZ;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_RAW_SAMPLE = 6'h00;
  localparam logic [5:0] IDX_VEND_OFS   = 6'h11;
  localparam logic [5:0] IDX_VEND_GAIN  = 6'h12;
  localparam logic [5:0] IDX_MAKER_OFS  = 6'h13;
  localparam logic [5:0] IDX_MAKER_GAIN = 6'h14;
  localparam logic [5:0] IDX_FEATURE    = 6'h20;
  localparam logic [5:0] IDX_USER_OFS   = 6'h21;
  localparam logic [5:0] IDX_USER_GAIN  = 6'h22;
  localparam logic [5:0] IDX_IRQ_STAT   = 6'h28;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h29;
  localparam logic [5:0] IDX_PD_WORD    = 6'h2A;

  // Reset values
  localparam logic [15:0] RST_VEND_OFS   = 16'h0000;
  localparam logic [15:0] RST_VEND_GAIN  = 16'h0400;
  localparam logic [15:0] RST_MAKER_OFS  = 16'h0000;
  localparam logic [15:0] RST_MAKER_GAIN = 16'h2002;
  localparam logic [15:0] RST_USER_OFS   = 16'h0000;
  localparam logic [15:0] RST_USER_GAIN  = 16'h0400;
  localparam logic [15:0] RST_FEATURE    = 16'h0002;
  localparam logic [2:0]  RST_IRQ_MASK   = 3'h0;

  // Feature register fields
  localparam int FEAT_USER_EN  = 0;
  localparam int FEAT_MAKER_EN = 1;
  localparam int FEAT_FMT_LSB  = 2;

  // Interrupt status bits
  localparam int IRQ_SAMPLE = 0;
  localparam int IRQ_CLIP   = 1;
  localparam int IRQ_WDOG   = 2;
  localparam int IRQ_BITS   = 3;

  // Status byte bits
  localparam int STB_OVER  = 0;
  localparam int STB_UNDER = 1;
  localparam int STB_WDOG  = 2;

  typedef enum logic [1:0] {
    FMT_TWOS    = 2'b00,
    FMT_SIGNMAG = 2'b01,
    FMT_ALT     = 2'b10,
    FMT_RSVD    = 2'b11
  } sps_fmt_t;

  typedef enum logic [1:0] {
    SEQ_START = 2'b00,
    SEQ_WAIT  = 2'b01,
    SEQ_CAL   = 2'b10,
    SEQ_OUT   = 2'b11
  } sps_seq_t;

  typedef struct packed {
    logic [15:0] offset;
    logic [15:0] gain;
  } sps_line_t;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0]  status;
  } sps_pdata_t;

endpackage
`default_nettype wire

// ### sps_scale_stage.sv
`timescale 1ns/100ps
`default_nettype none
module sps_scale_stage
  import sps_pkg::*;
#(
  parameter bit OFFSET_FIRST = 1'b0
) (
  input  wire logic [15:0] xIn,
  input  wire sps_line_t   line,
  output logic      [15:0] yOut,
  output logic             clipHi,
  output logic             clipLo
);

  // Offset before the gain for calibration, after it for scaling
  wire logic signed [16:0] preOfs =
    OFFSET_FIRST ? 17'($signed(line.offset)) : 17'sd0;
  wire logic signed [16:0] postOfs =
    OFFSET_FIRST ? 17'sd0 : 17'($signed(line.offset));
  wire logic signed [16:0] xSum = 17'($signed(xIn)) + preOfs;
  wire logic signed [32:0] product = xSum * 33'($signed(line.gain));
  wire logic signed [33:0] total =
    34'(product >>> GAIN_FRAC) + 34'(postOfs);

  assign clipHi = total > 34'sd32767;
  assign clipLo = total < -34'sd32768;
  assign yOut   = clipHi ? PD_MAX : (clipLo ? PD_MIN : total[15:0]);

endmodule
`default_nettype wire

// ### sps_pipeline_checker.sv
`timescale 1ns/100ps
`default_nettype none
module sps_pipeline_checker
  import sps_pkg::*;
#(
  parameter int WDOG_CYCLES = WDOG_CYCLES_DEF
) (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       convStart,
  input wire logic       adcDone,
  input wire logic       pdExchange,
  input wire sps_pdata_t pdOut,
  input wire logic       pdValid,
  input wire logic       runLed
);
  // Cycles since the exchange pin was last high
  int idle;
  always_ff @(posedge clock) begin
    if (!rstn || pdExchange) begin
      idle <= 0;
    end else if (idle < WDOG_CYCLES + 100) begin
      idle <= idle + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_taken;
    convStart ##[1:20] adcDone;
  endsequence
  property p_answer;
    s_taken |-> ##3 pdValid;
  endproperty
  a_answer: assert property (p_answer) else $error("no word");
  property p_start;
    pdValid |-> convStart;
  endproperty
  a_start: assert property (p_start) else $error("no restart");
  property p_pulse;
    pdValid |=> !pdValid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long valid");
  property p_status;
    pdValid |-> pdOut.status[7:3] == 5'h00;
  endproperty
  a_status: assert property (p_status) else $error("status");
  property p_hold;
    !pdValid |-> $stable(pdOut.data);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_late;
    $fell(runLed) |-> idle >= WDOG_CYCLES - 4;
  endproperty
  a_late: assert property (p_late) else $error("led early");
  property p_due;
    idle >= WDOG_CYCLES + 10 |-> !runLed;
  endproperty
  a_due: assert property (p_due) else $error("led stuck");
  sequence s_revive;
    $rose(pdExchange) && !runLed;
  endsequence
  property p_back;
    s_revive |-> ##[2:8] runLed;
  endproperty
  a_back: assert property (p_back) else $error("led off");
endmodule
`default_nettype wire

// ### sps_coupler_model.sv
`timescale 1ns/100ps
`default_nettype none
module sps_coupler_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        convStart,
  input  wire logic [11:0] code,
  input  wire logic        slow,
  input  wire logic        xchgOn,
  output logic      [11:0] adcCode,
  output logic             adcDone,
  output logic             pdExchange
);
  logic [3:0] cnt_q;
  logic       busy_q;
  logic [4:0] xc_q;
  logic       xOn_q;
  // Code lines carry junk outside the done strobe
  assign adcCode = adcDone ? code : ~code;
  // Enable taken at frame end so no exchange pulse is cut short
  assign pdExchange = xOn_q && (xc_q < 5'h02);
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      adcDone <= 1'b0;
      xc_q <= 5'h00;
      xOn_q <= 1'b1;
    end else begin
      adcDone <= busy_q && cnt_q == 4'h0;
      busy_q <= convStart || (busy_q && cnt_q != 4'h0);
      cnt_q <= convStart ? (slow ? 4'h9 : 4'h0) : cnt_q - 4'h1;
      xc_q <= (xc_q == 5'h13) ? 5'h00 : xc_q + 5'h01;
      xOn_q <= (xc_q == 5'h13) ? xchgOn : xOn_q;
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sps_pkg::*;
  localparam int WD = 64;
  logic        clock, rstn, ce, hsel, hwrite, slow, xchgOn;
  logic        hreadyout, hresp, convStart, adcDone, pdExchange;
  logic        pdValid, runLed, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] code, adcCode;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  sps_pdata_t  pdOut;
  int          n_mismatch, n_compared;

  sps_sample_pipeline #(.WDOG_CYCLES(WD)) sps_sample_pipeline_inst (
    .clock(clock), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .convStart(convStart), .adcCode(adcCode),
    .adcDone(adcDone), .pdExchange(pdExchange), .pdOut(pdOut),
    .pdValid(pdValid), .runLed(runLed), .irq(irq));
  sps_coupler_model sps_coupler_model_inst (
    .clock(clock), .rstn(rstn), .convStart(convStart), .code(code),
    .slow(slow), .xchgOn(xchgOn), .adcCode(adcCode),
    .adcDone(adcDone), .pdExchange(pdExchange));

  task wrap_up;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task xfer(input logic w, input logic [5:0] i, input logic [31:0] d);
    hwrite <= w;
    haddr <= {24'h00_0000, i, 2'b00};
    htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task wr(input logic [5:0] i, input logic [15:0] d);
    xfer(1'b1, i, {16'h0000, d});
  endtask
  task rd(input logic [5:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0000_0000);
    chk(rdv, e);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask
  task pd(input int n);
    int k;
    for (int j = 0; j < n; j++) begin
      k = 0;
      do begin
        @(posedge clock);
        k++;
      end while (pdValid !== 1'b1 && k < 40);
      chk({31'h0, pdValid}, 32'h0000_0001);
    end
  endtask
  task samp(input logic [11:0] c, input logic [15:0] d, input logic [7:0] s);
    code <= c;
    pd(2);
    chk({8'h00, pdOut.status, pdOut.data}, {8'h00, s, d});
  endtask
  task led(input logic v);
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (runLed !== v && k < 60);
    chk({31'h0, runLed}, {31'h0, v});
  endtask

  task t_regs;
    logic [5:0]  ix [5] = '{IDX_VEND_GAIN, IDX_MAKER_GAIN, IDX_FEATURE,
                           IDX_USER_GAIN, IDX_IRQ_MASK};
    logic [15:0] rv [5] = '{16'h0400, 16'h2002, 16'h0002, 16'h0400, 16'h0000};
    for (int j = 0; j < 5; j++) begin
      rd(ix[j], {16'h0000, rv[j]});
    end
    code <= 12'h123;
    pd(2);
    wr(IDX_RAW_SAMPLE, 16'h0ABC);
    rd(IDX_RAW_SAMPLE, 32'h0000_0123);
    rd(6'h3F, 32'h0000_0000);
  endtask
  task t_default;
    samp(12'h000, 16'h0000, 8'h00);
    samp(12'h7FF, 16'h3FFB, 8'h00);
    code <= 12'hFFF;
    pd(2);
    chk({16'h0000, pdOut.data}, 32'h0000_7FFF);
  endtask
  task t_modes;
    wr(IDX_USER_OFS, 16'h0005);
    wr(IDX_FEATURE, 16'h0000);
    samp(12'h064, 16'h0064, 8'h00);
    wr(IDX_FEATURE, 16'h0001);
    samp(12'h064, 16'h0069, 8'h00);
    slow <= 1'b1;
    wr(IDX_FEATURE, 16'h0003);
    samp(12'h064, 16'h0325, 8'h00);
    slow <= 1'b0;
    wr(IDX_FEATURE, 16'h0000);
    wr(IDX_VEND_OFS, 16'h0003);
    wr(IDX_VEND_GAIN, 16'h0800);
    samp(12'h064, 16'h00CE, 8'h00);
    wr(IDX_VEND_GAIN, 16'h0400);
  endtask
  task t_fmt;
    wr(IDX_VEND_OFS, 16'hFFFF);
    samp(12'h000, 16'hFFFF, 8'h00);
    wr(IDX_FEATURE, 16'h0004);
    samp(12'h000, 16'h8001, 8'h00);
    wr(IDX_FEATURE, 16'h0008);
    samp(12'h064, 16'h0060, 8'h00);
    wr(IDX_FEATURE, 16'h000C);
    samp(12'h064, 16'h0063, 8'h00);
  endtask
  task t_irq;
    wr(IDX_IRQ_MASK, 16'h0001);
    pd(1);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(IDX_IRQ_MASK, 16'h0002);
    xfer(1'b0, IDX_IRQ_STAT, 32'h0000_0000);
    chk(rdv & 32'h0000_0001, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask
  task t_clip;
    wr(IDX_VEND_OFS, 16'h0000);
    wr(IDX_FEATURE, 16'h0001);
    wr(IDX_USER_OFS, 16'h7FFF);
    samp(12'h064, 16'h7FFF, 8'h01);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(IDX_VEND_OFS, 16'hF000);
    wr(IDX_USER_OFS, 16'h8000);
    samp(12'h000, 16'h8000, 8'h02);
  endtask
  task t_wdog;
    do @(posedge clock); while (pdExchange !== 1'b1);
    xchgOn <= 1'b0;
    repeat (WD - 8) @(posedge clock);
    chk({31'h0, runLed}, 32'h0000_0001);
    led(1'b0);
    pd(1);
    chk({8'h00, pdOut.status, pdOut.data}, 32'h0006_8000);
    xfer(1'b0, IDX_IRQ_STAT, 32'h0000_0000);
    chk(rdv & 32'h0000_0004, 32'h0000_0004);
    xfer(1'b0, IDX_IRQ_STAT, 32'h0000_0000);
    chk(rdv & 32'h0000_0004, 32'h0000_0000);
    xchgOn <= 1'b1;
    led(1'b1);
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    wrap_up;
  end
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rstn = 1'b0;
    ce = 1'b1;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    code = 12'h000;
    slow = 1'b0;
    xchgOn = 1'b1;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    t_regs;
    t_default;
    t_modes;
    t_fmt;
    t_irq;
    t_clip;
    t_wdog;
    wrap_up;
  end
endmodule

bind sps_sample_pipeline sps_pipeline_checker #(
  .WDOG_CYCLES(WDOG_CYCLES)
) sps_pipeline_checker_inst (
  .clock(clock), .rstn(rstn), .convStart(convStart), .adcDone(adcDone),
  .pdExchange(pdExchange), .pdOut(pdOut), .pdValid(pdValid),
  .runLed(runLed));
`default_nettype wire
